/* rtl/battery_charge_supervisor_fsm.sv */
// Charge-cycle supervisor: state machine, timers, status pins, APB registers
//
// Overview of operation
// - Out-of-window temperature pauses charge, flags fault
// - Sense below disable level ignores temperature
// - Cold above 74%, hot below 37%
// - Safety timer holds in constant-current mode
// - Recharge threshold crossing clears safety timer, unless it meets a tick in CV
// - Float reached starts two-hour safety timeout
// - Below C/10 release charge pin, keep top-off
// - Safety expiry stops charge, enters sleep
// - Sleep dip 2.2% clears timer, restarts cycle
// - Recharge trigger qualified by 0.5 ms delay
// - Charge pin open-drain, low above C/10
// - Fault pin low on bad battery or thermal
// - Thermal keeps charge pin low; bad battery releases
// - Deep discharge: precondition current only, switcher off
// - Above deep level: switcher at trickle current
// - Above trickle threshold: full current, precondition off
// - Below trickle over 30 minutes: bad battery
// - Battery swap after bad battery restarts cycle
// - Run hysteresis 2.45/2.25 V, shutdown below 0.7 V
// - Disabled: status pins released, ground return open
// - Differential undervoltage forces shutdown until recovered
// - Fixed-float variant judges deep and trickle levels from battery sense
`timescale 1ns/1ps
`include "charge_map.svh"
module battery_charge_supervisor_fsm #(
  parameter logic [29:0] SAFETY_TICKS = 30'(`SAFETY_TICKS_DEF),
  parameter logic [27:0] BADBAT_TICKS = 28'(`BADBAT_TICKS_DEF)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire charge_pkg::cmp_s comparators,
  input wire logic charge_status_n_in,
  input wire logic fault_status_n_in,
  output logic charge_status_n_out,
  output logic charge_status_n_oe,
  output logic fault_status_n_out,
  output logic fault_status_n_oe,
  output charge_pkg::drive_s drive
);
  typedef struct packed {
    charge_pkg::state_e state;
    logic enabled;
    logic thermal_fault;
    logic removed;
    logic rchg_prev;
    logic [9:0] prescale;
    logic tick;
    logic [29:0] safety;
    logic [27:0] badbat;
    logic [5:0] rdelay;
    logic ctrl_fixed;
    logic ctrl_inhibit;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic od_level;
    logic chg_oe;
    logic flt_oe;
    charge_pkg::drive_s drive;
  } st_s;

  st_s q;
  st_s next_q;
  logic [16:0] sync_vec;
  charge_pkg::cmp_s c;
  logic pin_chg;
  logic pin_flt;

  sync_pair #(.WIDTH(17)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({comparators, charge_status_n_in, fault_status_n_in}),
    .sync_out(sync_vec)
  );

  assign c = charge_pkg::cmp_s'(sync_vec[16:2]);
  assign pin_chg = sync_vec[1];
  assign pin_flt = sync_vec[0];

  logic active;
  logic deep_ok;
  logic trickle_ok;
  logic temp_bad;
  logic charging;
  logic access;
  logic wr_commit;
  logic mapped;
  logic [31:0] rd_value;

  always_comb begin
    // Variant select for level sensing
    deep_ok = q.ctrl_fixed ? c.bs_above_deep : c.fb_above_deep;
    trickle_ok = q.ctrl_fixed ? c.bs_above_trickle : c.fb_above_trickle;
    // Hot and cold arrive as ratiometric comparator levels
    temp_bad = !c.therm_disable && (c.therm_hot || c.therm_cold);
    active = q.enabled && c.run_above_shutdown && !c.differential_undervoltage_lockout;
    charging = (q.state == charge_pkg::ST_PRECOND) || (q.state == charge_pkg::ST_TRICKLE)
      || (q.state == charge_pkg::ST_CC) || (q.state == charge_pkg::ST_CV);
    access = psel && penable && !q.pready;
    wr_commit = psel && penable && q.pready && pwrite;
    mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS)
      || (paddr == `REG_SAFETY) || (paddr == `REG_BADBAT);
    rd_value = '0;
    unique case (paddr)
      `REG_CTRL: begin
        rd_value[`CTRL_FIXED_BIT] = q.ctrl_fixed;
        rd_value[`CTRL_INHIBIT_BIT] = q.ctrl_inhibit;
      end
      `REG_STATUS: begin
        rd_value[6:0] = q.state;
        rd_value[`STATUS_THERMAL_BIT] = q.thermal_fault;
        rd_value[`STATUS_BADBAT_BIT] = (q.state == charge_pkg::ST_BADBAT);
        rd_value[`STATUS_ENABLED_BIT] = q.enabled;
        rd_value[`STATUS_CMP_LSB +: 17] = {c, pin_chg, pin_flt};
      end
      `REG_SAFETY: rd_value[29:0] = q.safety;
      `REG_BADBAT: rd_value[27:0] = q.badbat;
      default: rd_value = '0;
    endcase
  end

  always_comb begin
    next_q = q;
    next_q.od_level = 1'b0;

    // Prescaled tick
    if (q.prescale == `TICK_LAST) begin
      next_q.prescale = '0;
      next_q.tick = 1'b1;
    end else begin
      next_q.prescale = q.prescale + 10'h001;
      next_q.tick = 1'b0;
    end

    // Run pin hysteresis
    if (c.run_above_enable) begin
      next_q.enabled = 1'b1;
    end else if (!c.run_above_stop) begin
      next_q.enabled = 1'b0;
    end

    // Thermal pause only while a cycle runs
    next_q.thermal_fault = charging && temp_bad;

    next_q.rchg_prev = c.fb_above_recharge;
    if (c.fb_above_recharge != q.rchg_prev) begin
      next_q.safety = '0;
    end

    if (!active || q.ctrl_inhibit) begin
      next_q.state = charge_pkg::ST_OFF;
      next_q.thermal_fault = 1'b0;
      next_q.safety = '0;
      next_q.badbat = '0;
      next_q.rdelay = '0;
    end else begin
      unique case (q.state)
        charge_pkg::ST_OFF: begin
          next_q.state = charge_pkg::ST_PRECOND;
        end
        charge_pkg::ST_PRECOND, charge_pkg::ST_TRICKLE: begin
          if (q.tick && !q.thermal_fault) begin
            next_q.badbat = q.badbat + 28'h0000001;
          end
          if (q.badbat >= BADBAT_TICKS) begin
            next_q.state = charge_pkg::ST_BADBAT;
            next_q.removed = 1'b0;
          end else if (deep_ok && trickle_ok) begin
            next_q.state = charge_pkg::ST_CC;
            next_q.badbat = '0;
          end else if (deep_ok) begin
            next_q.state = charge_pkg::ST_TRICKLE;
          end else begin
            next_q.state = charge_pkg::ST_PRECOND;
          end
        end
        charge_pkg::ST_CC: begin
          // Timer holds here
          if (c.float_reached) begin
            next_q.state = charge_pkg::ST_CV;
          end
        end
        charge_pkg::ST_CV: begin
          if (q.tick && !q.thermal_fault) begin
            next_q.safety = q.safety + 30'h00000001;
          end
          if (q.safety >= SAFETY_TICKS) begin
            next_q.state = charge_pkg::ST_SLEEP;
            next_q.rdelay = '0;
          end
        end
        charge_pkg::ST_SLEEP: begin
          if (c.fb_above_recharge) begin
            next_q.rdelay = '0;
          end else if (q.rdelay >= `RECHARGE_TICKS) begin
            next_q.state = charge_pkg::ST_PRECOND;
            next_q.safety = '0;
            next_q.badbat = '0;
            next_q.rdelay = '0;
          end else if (q.tick) begin
            next_q.rdelay = q.rdelay + 6'h01;
          end
        end
        charge_pkg::ST_BADBAT: begin
          if (!c.battery_present) begin
            next_q.removed = 1'b1;
          end else if (q.removed) begin
            next_q.state = charge_pkg::ST_PRECOND;
            next_q.badbat = '0;
            next_q.safety = '0;
            next_q.removed = 1'b0;
          end
        end
        default: begin
          next_q.state = charge_pkg::ST_OFF;
        end
      endcase
    end

    // Power path drive, paused during thermal fault
    next_q.drive.switcher_enable = !q.thermal_fault && ((q.state == charge_pkg::ST_TRICKLE)
      || (q.state == charge_pkg::ST_CC) || (q.state == charge_pkg::ST_CV));
    next_q.drive.trickle_current = !q.thermal_fault
      && (q.state == charge_pkg::ST_TRICKLE);
    next_q.drive.precondition_current = !q.thermal_fault
      && ((q.state == charge_pkg::ST_PRECOND) || (q.state == charge_pkg::ST_TRICKLE));
    next_q.drive.feedback_ground_return_oe = active;
    next_q.drive.sleep_mode = (q.state == charge_pkg::ST_SLEEP);
    next_q.drive.shutdown_mode = !c.run_above_shutdown
      || c.differential_undervoltage_lockout;

    // Status pins, released whenever disabled
    next_q.chg_oe = active && charging && (q.thermal_fault
      || c.above_c10);
    next_q.flt_oe = active && ((charging && q.thermal_fault)
      || (q.state == charge_pkg::ST_BADBAT));

    // APB slave: one wait state, writes at the completing edge
    next_q.pready = access;
    next_q.pslverr = access && !mapped;
    if (access && !pwrite) begin
      next_q.prdata = rd_value;
    end
    if (wr_commit && (paddr == `REG_CTRL)) begin
      next_q.ctrl_fixed = pwdata[`CTRL_FIXED_BIT];
      next_q.ctrl_inhibit = pwdata[`CTRL_INHIBIT_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.state <= charge_pkg::ST_OFF;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign charge_status_n_out = q.od_level;
  assign charge_status_n_oe = q.chg_oe;
  assign fault_status_n_out = q.od_level;
  assign fault_status_n_oe = q.flt_oe;
  assign drive = q.drive;
endmodule : battery_charge_supervisor_fsm

/* rtl/charge_map.svh */
// Named constants for the charge supervisor: timing, register map and fields
`ifndef CHARGE_MAP_SVH
`define CHARGE_MAP_SVH

`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 10000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_LAST 10'(`TICK_CYCLES - 1)

`define SAFETY_TIME_S 7200
`define SAFETY_TICKS_DEF \
  (64'(`SAFETY_TIME_S) * 64'd1000000000 / 64'(`TICK_PERIOD_NS))
`define BADBAT_TIME_MIN 30
`define BADBAT_TICKS_DEF \
  (64'(`BADBAT_TIME_MIN) * 64'd60000000000 / 64'(`TICK_PERIOD_NS))
`define RECHARGE_DELAY_US 500
`define RECHARGE_TICKS \
  6'((`RECHARGE_DELAY_US * 1000 + `TICK_PERIOD_NS - 1) / `TICK_PERIOD_NS)

// Comparator trip points, applied in the analog front end
`define THERM_COLD_PCT 74
`define THERM_HOT_PCT 37
`define THERM_DISABLE_MV 85
`define RUN_ENABLE_MV 2450
`define RUN_STOP_MV 2250
`define RUN_SHUTDOWN_MV 700
`define RECHARGE_DROP_PERMILLE 22

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SAFETY 8'h08
`define REG_BADBAT 8'h0C
`define CTRL_FIXED_BIT 0
`define CTRL_INHIBIT_BIT 1
`define STATUS_THERMAL_BIT 8
`define STATUS_BADBAT_BIT 9
`define STATUS_ENABLED_BIT 10
`define STATUS_CMP_LSB 15

`endif

/* rtl/charge_pkg.sv */
// Types shared by the charge supervisor files
package charge_pkg;

  typedef enum logic [6:0] {
    ST_OFF     = 7'h01,
    ST_PRECOND = 7'h02,
    ST_TRICKLE = 7'h04,
    ST_CC      = 7'h08,
    ST_CV      = 7'h10,
    ST_SLEEP   = 7'h20,
    ST_BADBAT  = 7'h40
  } state_e;

  typedef struct packed {
    logic therm_cold;
    logic therm_hot;
    logic therm_disable;
    logic fb_above_deep;
    logic fb_above_trickle;
    logic fb_above_recharge;
    logic bs_above_deep;
    logic bs_above_trickle;
    logic run_above_enable;
    logic run_above_stop;
    logic run_above_shutdown;
    logic differential_undervoltage_lockout;
    logic float_reached;
    logic above_c10;
    logic battery_present;
  } cmp_s;

  typedef struct packed {
    logic switcher_enable;
    logic trickle_current;
    logic precondition_current;
    logic feedback_ground_return_oe;
    logic sleep_mode;
    logic shutdown_mode;
  } drive_s;

endpackage : charge_pkg

/* rtl/sync_pair.sv */
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module sync_pair #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_s;

  sync_s q;
  sync_s next_q;

  always_comb begin
    next_q.first = async_in;
    next_q.second = q.first;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sync_out = q.second;
endmodule : sync_pair

/* test/charge_sva.sv */
// Port assertions for the charge supervisor
`timescale 1ns/1ps
module charge_sva #(
  parameter logic [29:0] SAFETY_TICKS = 30'h8,
  parameter logic [27:0] BADBAT_TICKS = 28'h5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire charge_pkg::cmp_s comparators,
  input wire logic charge_status_n_out,
  input wire logic charge_status_n_oe,
  input wire logic fault_status_n_out,
  input wire logic fault_status_n_oe,
  input wire charge_pkg::drive_s drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence locked;
    comparators.differential_undervoltage_lockout [*6];
  endsequence
  sequence stopped;
    (!comparators.run_above_stop) [*6];
  endsequence
  AST_OD_LOW: assert property (!charge_status_n_out && !fault_status_n_out)
    else $error("pin data high");
  AST_TRICKLE: assert property (drive.trickle_current |->
    drive.switcher_enable && drive.precondition_current) else $error("trickle");
  AST_FULL: assert property (drive.switcher_enable && !drive.trickle_current |->
    !drive.precondition_current) else $error("full");
  AST_THERMAL: assert property (charge_status_n_oe && fault_status_n_oe |->
    !drive.switcher_enable && !drive.precondition_current) else $error("thermal");
  AST_THERM_OFF: assert property (comparators.therm_disable [*6] |->
    !(charge_status_n_oe && fault_status_n_oe)) else $error("therm off");
  AST_SLEEP: assert property (drive.sleep_mode |->
    !drive.switcher_enable && !charge_status_n_oe) else $error("sleep");
  AST_LOCKOUT: assert property (locked |->
    drive.shutdown_mode && !drive.switcher_enable) else $error("lockout");
  AST_RUN_STOP: assert property (stopped |-> !drive.switcher_enable &&
    !drive.feedback_ground_return_oe && !charge_status_n_oe && !fault_status_n_oe)
    else $error("run stop");
endmodule : charge_sva
bind battery_charge_supervisor_fsm charge_sva #(.SAFETY_TICKS(SAFETY_TICKS),
  .BADBAT_TICKS(BADBAT_TICKS)) chk (.pclk, .presetn, .comparators, .charge_status_n_out,
  .charge_status_n_oe, .fault_status_n_out, .fault_status_n_oe, .drive);

/* test/battery_pack.sv */
// Battery pack model: comparator levels and pulled-up status lines
`timescale 1ns/1ps
module battery_pack (
  input wire charge_pkg::cmp_s want,
  input wire logic charge_status_n_out,
  input wire logic charge_status_n_oe,
  input wire logic fault_status_n_out,
  input wire logic fault_status_n_oe,
  output charge_pkg::cmp_s comparators,
  output logic charge_status_n_in,
  output logic fault_status_n_in
);
  assign comparators = want;
  // Pull-up wins unless pin driven
  assign charge_status_n_in = charge_status_n_oe ? charge_status_n_out : 1'b1;
  assign fault_status_n_in = fault_status_n_oe ? fault_status_n_out : 1'b1;
endmodule : battery_pack

/* test/testbench.sv */
// Testbench for the charge supervisor
`timescale 1ns/1ps
`include "charge_map.svh"
`define CK(n, x, g) begin checks_done++; if ((g) !== (x)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", n, x, g); end end
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, co, cx, fo, fx, cin, fin;
  charge_pkg::cmp_s want = 15'h0000, cmp;
  charge_pkg::drive_s drv;
  int miscompares = 0, checks_done = 0, cycles = 0;
  always #5 pclk = ~pclk;
  battery_charge_supervisor_fsm #(.SAFETY_TICKS(30'h8), .BADBAT_TICKS(28'h5)) dut (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .comparators(cmp), .charge_status_n_in(cin), .fault_status_n_in(fin),
    .charge_status_n_out(co), .charge_status_n_oe(cx), .fault_status_n_out(fo),
    .fault_status_n_oe(fx), .drive(drv));
  battery_pack pack (.want, .charge_status_n_out(co), .charge_status_n_oe(cx),
    .fault_status_n_out(fo), .fault_status_n_oe(fx), .comparators(cmp),
    .charge_status_n_in(cin), .fault_status_n_in(fin));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask : cy
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic st(input logic [6:0] x);
    apb(1'b0, `REG_STATUS, 32'h0);
    `CK("state", x, r[6:0])
  endtask : st
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    cy(6);
    presetn <= 1'b1;
    st(charge_pkg::ST_OFF);
    apb(1'b0, 8'h10, 32'h0);
    `CK("slverr", 1'b1, e)
    apb(1'b1, `REG_STATUS, 32'h7F);
    st(charge_pkg::ST_OFF);
    `CK("pins", 2'b11, {cin, fin})
    $display("test reset done");
    want <= 15'h0273;
    cy(8);
    st(charge_pkg::ST_PRECOND);
    `CK("drive", 6'h0C, drv)
    want.fb_above_deep <= 1'b1;
    cy(8);
    `CK("drive", 6'h3C, drv)
    want.fb_above_trickle <= 1'b1;
    cy(8);
    `CK("drive", 6'h24, drv)
    `CK("chg", 1'b0, cin)
    cy(11000);
    st(charge_pkg::ST_CC);
    want.therm_cold <= 1'b1;
    cy(8);
    `CK("pins", 2'b00, {cin, fin})
    `CK("sw", 1'b0, drv.switcher_enable)
    want.therm_disable <= 1'b1;
    cy(8);
    `CK("flt", 1'b1, fin)
    want.therm_cold <= 1'b0;
    want.therm_disable <= 1'b0;
    want.therm_hot <= 1'b1;
    cy(8);
    `CK("flt", 1'b0, fin)
    want.therm_hot <= 1'b0;
    cy(8);
    `CK("pins", 2'b01, {cin, fin})
    $display("test thermal done");
    want.float_reached <= 1'b1;
    want.above_c10 <= 1'b0;
    cy(4000);
    st(charge_pkg::ST_CV);
    `CK("chg", 1'b1, cin)
    cy(6000);
    st(charge_pkg::ST_SLEEP);
    want.fb_above_recharge <= 1'b0;
    cy(8);
    apb(1'b0, `REG_SAFETY, 32'h0);
    `CK("safety", 32'h0, r)
    cy(45000);
    `CK("sleep", 1'b1, drv.sleep_mode)
    cy(10000);
    `CK("sleep", 1'b0, drv.sleep_mode)
    $display("test cycle done");
    want.differential_undervoltage_lockout <= 1'b1;
    cy(8);
    `CK("shdn", 1'b1, drv.shutdown_mode)
    st(charge_pkg::ST_OFF);
    want <= 15'h0213;
    cy(8);
    st(charge_pkg::ST_OFF);
    `CK("drive", 6'h00, drv)
    `CK("pins", 2'b11, {cin, fin})
    want <= 15'h0203;
    cy(8);
    `CK("shdn", 1'b1, drv.shutdown_mode)
    $display("test supply done");
    want <= 15'h0273;
    cy(7000);
    st(charge_pkg::ST_BADBAT);
    `CK("pins", 2'b10, {cin, fin})
    want.battery_present <= 1'b0;
    cy(8);
    want.battery_present <= 1'b1;
    cy(8);
    st(charge_pkg::ST_PRECOND);
    apb(1'b1, `REG_CTRL, 32'h1);
    want.bs_above_deep <= 1'b1;
    cy(8);
    st(charge_pkg::ST_TRICKLE);
    $display("test badbat done");
    conclude();
  end
endmodule : testbench
